// file: core/wdt_pkg.sv
// constants shared by the watchdog core and its helpers
// assumes a 100 MHz core clock and an 8-bit I/O port bus on one clock
package wdt_pkg;

   // ==========================================================
   // host I/O bus
   localparam int unsigned DATA_W          = 8;
   localparam int unsigned ADDR_W          = 16;
   localparam logic [15:0] INDEX_PORT_ADDR = 16'h002e;
   localparam logic [15:0] DATA_PORT_ADDR  = 16'h002f;

   // ==========================================================
   // configuration keys and register indices
   localparam logic [7:0]  UNLOCK_KEY      = 8'h87;
   localparam logic [7:0]  LOCK_KEY        = 8'haa;
   localparam logic [7:0]  IDX_LDEV_SEL    = 8'h07;
   localparam logic [7:0]  IDX_ACTIVATE    = 8'h30;
   localparam logic [7:0]  IDX_UNIT        = 8'hf5;
   localparam logic [7:0]  IDX_COUNT       = 8'hf6;
   localparam logic [7:0]  IDX_CTRL        = 8'hf7;
   localparam logic [7:0]  LDEV_WATCHDOG   = 8'h08;
   localparam logic [7:0]  RST_BYTE        = 8'h00;
   localparam logic [7:0]  COUNT_STOPPED   = 8'h00;
   localparam logic [7:0]  COUNT_LAST      = 8'h01;

   // ==========================================================
   // field positions
   localparam int unsigned ACT_EN_BIT      = 0;
   localparam int unsigned UNIT_MIN_BIT    = 3;
   localparam int unsigned UNIT_FAST_BIT   = 4;
   localparam int unsigned CTRL_KBD_BIT    = 6;
   localparam int unsigned CTRL_FORCE_BIT  = 5;
   localparam int unsigned CTRL_STATUS_BIT = 4;

   // ==========================================================
   // timing
   localparam int unsigned CLK_PERIOD_NS   = 10;
   localparam int unsigned MS_NS           = 1000000;
   localparam int unsigned MS_CYCLES       = MS_NS / CLK_PERIOD_NS;
   localparam int unsigned PRESCALE_W      = 17;
   localparam int unsigned UNIT_W          = 16;
   localparam logic [15:0] MS_PER_SEC      = 16'h03e8;
   localparam logic [15:0] MS_PER_MIN      = 16'hea60;
   localparam logic [15:0] MS_PER_FAST_SEC = 16'h0001;
   localparam logic [15:0] MS_PER_FAST_MIN = 16'h003c;

   // ==========================================================
   // configuration access state
   typedef enum logic [1:0] {
      CFG_LOCKED   = 2'b00,
      CFG_KEY_SEEN = 2'b01,
      CFG_OPEN     = 2'b10
   } cfg_state_t;

endpackage

// file: core/unit_tick_if.sv
// carrier between the watchdog core and its unit tick generator
// assumes both ends sit on the same core clock
`timescale 1ns/100ps
interface unit_tick_if;
   logic unit_minutes;
   logic unit_fast;
   logic restart;
   logic tick;

   // ==========================================================
   // tick generator end and consumer end
   modport gen  (input unit_minutes, input unit_fast, input restart,
                 output tick);
   modport user (output unit_minutes, output unit_fast, output restart,
                 input tick);
endinterface

// file: core/unit_tick_gen.sv
// one-cycle tick per selected count unit
// assumes restart is a same-clock level from the watchdog core
`timescale 1ns/100ps
module unit_tick_gen #(
   parameter int unsigned CYCLES_PER_MS = wdt_pkg::MS_CYCLES
) (
   // clock and reset
   input  wire logic   i_clk,
   input  wire logic   i_nrst,
   // unit selection and tick
   unit_tick_if.gen    tick_bus
);
   import wdt_pkg::*;

   // ==========================================================
   // elaboration checks
   if (CYCLES_PER_MS < 1 || CYCLES_PER_MS > (1 << PRESCALE_W)) begin : g_chk
      $error("CYCLES_PER_MS out of range");
   end

   localparam logic [PRESCALE_W-1:0] MS_LAST =
      PRESCALE_W'(CYCLES_PER_MS - 1);

   logic [PRESCALE_W-1:0] ms_cnt_reg;
   logic [UNIT_W-1:0]     unit_cnt_reg;
   logic                  ms_tick;
   logic                  tick_reg;

   // milliseconds per unit; fast mode is a thousandth of the unit
   function automatic logic [UNIT_W-1:0] unit_ms(input logic minutes,
                                                 input logic fast);
      unit_ms = minutes ? (fast ? MS_PER_FAST_MIN : MS_PER_MIN)
                        : (fast ? MS_PER_FAST_SEC : MS_PER_SEC);
   endfunction

   assign ms_tick = (ms_cnt_reg == MS_LAST);

   // millisecond prescaler
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst)
         ms_cnt_reg <= '0;
      else if (tick_bus.restart || ms_tick)
         ms_cnt_reg <= '0;
      else
         ms_cnt_reg <= ms_cnt_reg + 1'b1;
   end

   // unit counter; a unit change applies from the next millisecond
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         unit_cnt_reg <= '0;
         tick_reg     <= 1'b0;
      end else if (tick_bus.restart) begin
         unit_cnt_reg <= '0;
         tick_reg     <= 1'b0;
      end else if (ms_tick) begin
         if (unit_cnt_reg + 1'b1 >=
             unit_ms(tick_bus.unit_minutes, tick_bus.unit_fast)) begin
            unit_cnt_reg <= '0;
            tick_reg     <= 1'b1;
         end else begin
            unit_cnt_reg <= unit_cnt_reg + 1'b1;
            tick_reg     <= 1'b0;
         end
      end else begin
         tick_reg <= 1'b0;
      end
   end

   assign tick_bus.tick = tick_reg;
endmodule

// file: core/pin_sync.sv
// three-stage synchroniser with a stable level and a rising pulse
// assumes an asynchronous pin input
`timescale 1ns/100ps
module pin_sync (
   // clock and reset
   input  wire logic i_clk,
   input  wire logic i_nrst,
   // pin in, clean level and edge out
   input  wire logic i_pin,
   output logic      o_level,
   output logic      o_rise
);
   logic s1_reg;
   logic s2_reg;
   logic s3_reg;
   logic level_reg;
   logic rise_reg;

   // only s2 reads s1, so metastability stays in the first stage
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         s1_reg <= 1'b0;
         s2_reg <= 1'b0;
         s3_reg <= 1'b0;
      end else begin
         s1_reg <= i_pin;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   // a change counts once stages two and three agree
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         level_reg <= 1'b0;
         rise_reg  <= 1'b0;
      end else begin
         rise_reg <= (s2_reg == s3_reg) && s2_reg && !level_reg;
         if (s2_reg == s3_reg)
            level_reg <= s2_reg;
      end
   end

   assign o_level = level_reg;
   assign o_rise  = rise_reg;
endmodule

// file: core/indexed_port_watchdog_timer.sv
// watchdog timer behind an index/data configuration port pair
// assumes single-cycle read and write strobes on the core clock
//
// Functional notes
// - index port at 2e selects a register, data port at 2f accesses it
// - each data access uses the index most recently written while config space is open
// - two consecutive unlock key writes to index port open config space
// - lock key written to index port closes config space again
// - value 08 at index 07 selects the watchdog register set
// - writing 01 at index 30 enables the watchdog; off after reset
// - unit bit 3: 0 counts seconds (default), 1 counts minutes
// - unit bit 4 makes the unit a thousandth of the bit 3 unit
// - count zero stops the timer; 01 to ff set timeout length
// - count running out without a new write asserts timeout output
// - every count write restarts the timer from the written value
// - control bit 6 lets keyboard activity reload the timer
// - control bit 5 write forces timeout at once, then reads zero
// - control bit 4 reads one after the watchdog has timed out
`timescale 1ns/100ps
module indexed_port_watchdog_timer #(
   parameter int unsigned CYCLES_PER_MS = wdt_pkg::MS_CYCLES
) (
   // clock and reset
   input  wire logic                        i_clk,
   input  wire logic                        i_nrst,
   // host I/O port bus
   input  wire logic [wdt_pkg::ADDR_W-1:0] i_io_addr,
   input  wire logic                        i_io_wr,
   input  wire logic                        i_io_rd,
   input  wire logic [wdt_pkg::DATA_W-1:0] i_io_wdata,
   output logic      [wdt_pkg::DATA_W-1:0] o_io_rdata,
   output logic                             o_io_rvalid,
   // keyboard activity pin
   input  wire logic                        i_kbd_activity,
   // watchdog outputs
   output logic                             o_wdt_timeout,
   output logic                             o_timeout_status,
   output logic                             o_wdt_running
);
   import wdt_pkg::*;

   // ==========================================================
   // declarations

   cfg_state_t        cfg_state_reg;
   cfg_state_t        cfg_state_next;
   logic [DATA_W-1:0] index_reg;
   logic [DATA_W-1:0] ldev_reg;
   logic [DATA_W-1:0] activate_reg;
   logic [DATA_W-1:0] unit_reg;
   logic [DATA_W-1:0] reload_reg;
   logic [DATA_W-1:0] count_reg;
   logic [DATA_W-1:0] count_next;
   logic              kbd_en_reg;
   logic              status_reg;
   logic              timeout_reg;
   logic              running_reg;
   logic [DATA_W-1:0] rdata_reg;
   logic              rvalid_reg;

   logic              idx_wr;
   logic              data_wr;
   logic              data_rd;
   logic              idx_rd;
   logic              cfg_open;
   logic              wdt_sel;
   logic              wr_ldev;
   logic              wr_activate;
   logic              wr_unit;
   logic              wr_count;
   logic              wr_ctrl;
   logic              wdt_active;
   logic              force_timeout;
   logic              kbd_rise;
   logic              kbd_reload;
   logic              expire;
   logic              status_clr;

   unit_tick_if       tick_bus ();

   // ==========================================================
   // helpers

   // watchdog register hit for a given index
   function automatic logic wdt_hit(input logic sel,
                                    input logic [DATA_W-1:0] idx,
                                    input logic [DATA_W-1:0] want);
      wdt_hit = sel && (idx == want);
   endfunction

   // readback image of the control and status register
   function automatic logic [DATA_W-1:0] ctrl_image(input logic kbd,
                                                    input logic stat);
      logic [DATA_W-1:0] img;
      img                  = RST_BYTE;
      img[CTRL_KBD_BIT]    = kbd;
      img[CTRL_STATUS_BIT] = stat;
      ctrl_image = img;
   endfunction

   // ==========================================================
   // port decode

   // address match on the two ports only
   assign idx_wr  = i_io_wr && (i_io_addr == INDEX_PORT_ADDR);
   assign idx_rd  = i_io_rd && (i_io_addr == INDEX_PORT_ADDR);
   assign data_wr = i_io_wr && (i_io_addr == DATA_PORT_ADDR)
                    && cfg_open;
   assign data_rd = i_io_rd && (i_io_addr == DATA_PORT_ADDR);

   assign cfg_open = (cfg_state_reg == CFG_OPEN);
   assign wdt_sel  = (ldev_reg == LDEV_WATCHDOG);

   // register write strobes
   assign wr_ldev     = data_wr && (index_reg == IDX_LDEV_SEL);
   assign wr_activate = data_wr && wdt_hit(wdt_sel, index_reg,
                                           IDX_ACTIVATE);
   assign wr_unit     = data_wr && wdt_hit(wdt_sel, index_reg,
                                           IDX_UNIT);
   assign wr_count    = data_wr && wdt_hit(wdt_sel, index_reg,
                                           IDX_COUNT);
   assign wr_ctrl     = data_wr && wdt_hit(wdt_sel, index_reg,
                                           IDX_CTRL);

   // ==========================================================
   // configuration lock state

   // any index write other than the key breaks the unlock pair
   always_comb begin
      cfg_state_next = cfg_state_reg;
      case (cfg_state_reg)
         CFG_LOCKED: begin
            if (idx_wr && i_io_wdata == UNLOCK_KEY)
               cfg_state_next = CFG_KEY_SEEN;
         end
         CFG_KEY_SEEN: begin
            if (idx_wr)
               cfg_state_next = (i_io_wdata == UNLOCK_KEY) ?
                                CFG_OPEN : CFG_LOCKED;
         end
         CFG_OPEN: begin
            if (idx_wr && i_io_wdata == LOCK_KEY)
               cfg_state_next = CFG_LOCKED;
         end
         default: begin
            cfg_state_next = CFG_LOCKED;
         end
      endcase
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst)
         cfg_state_reg <= CFG_LOCKED;
      else
         cfg_state_reg <= cfg_state_next;
   end

   // index latch while open; the lock key is not stored as an index
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst)
         index_reg <= RST_BYTE;
      else if (idx_wr && cfg_open && i_io_wdata != LOCK_KEY)
         index_reg <= i_io_wdata;
   end

   // ==========================================================
   // configuration registers

   // logical device select
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst)
         ldev_reg <= RST_BYTE;
      else if (wr_ldev)
         ldev_reg <= i_io_wdata;
   end

   // activation; watchdog held off until software enables it
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst)
         activate_reg <= RST_BYTE;
      else if (wr_activate)
         activate_reg <= i_io_wdata;
   end

   // count unit selection, seconds by default
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst)
         unit_reg <= RST_BYTE;
      else if (wr_unit)
         unit_reg <= i_io_wdata;
   end

   // last written count, used again by keyboard reloads
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst)
         reload_reg <= COUNT_STOPPED;
      else if (wr_count)
         reload_reg <= i_io_wdata;
   end

   // keyboard reload enable, off by default
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst)
         kbd_en_reg <= 1'b0;
      else if (wr_ctrl)
         kbd_en_reg <= i_io_wdata[CTRL_KBD_BIT];
   end

   // ==========================================================
   // unit ticks and keyboard input

   assign wdt_active = activate_reg[ACT_EN_BIT];

   // bit 3 picks minutes, bit 4 divides the unit by a thousand
   assign tick_bus.unit_minutes = unit_reg[UNIT_MIN_BIT];
   assign tick_bus.unit_fast    = unit_reg[UNIT_FAST_BIT];

   // realign the unit grid so a fresh count gets a full first unit
   assign tick_bus.restart = wr_count || kbd_reload || !wdt_active;

   unit_tick_gen #(
      .CYCLES_PER_MS (CYCLES_PER_MS)
   ) u_tick (
      .i_clk    (i_clk),
      .i_nrst   (i_nrst),
      .tick_bus (tick_bus)
   );

   pin_sync u_kbd_sync (
      .i_clk   (i_clk),
      .i_nrst  (i_nrst),
      .i_pin   (i_kbd_activity),
      .o_level (),
      .o_rise  (kbd_rise)
   );

   // keyboard strobe only refreshes a running countdown
   assign kbd_reload = kbd_en_reg && kbd_rise && wdt_active
                       && (count_reg != COUNT_STOPPED)
                       && !wr_count;

   // ==========================================================
   // countdown

   // expiry on the last unit of a running count
   assign expire = wdt_active && !wr_count && !kbd_reload
                   && tick_bus.tick
                   && (count_reg == COUNT_LAST);

   // forced timeout bit is a strobe and is never stored
   assign force_timeout = wr_ctrl && i_io_wdata[CTRL_FORCE_BIT];

   always_comb begin
      count_next = count_reg;
      if (wr_count)
         count_next = i_io_wdata;
      else if (kbd_reload)
         count_next = reload_reg;
      else if (wdt_active && tick_bus.tick
               && count_reg != COUNT_STOPPED)
         count_next = count_reg - COUNT_LAST;
   end

   // zero means stopped; expiry leaves the count at zero
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst)
         count_reg <= COUNT_STOPPED;
      else
         count_reg <= count_next;
   end

   // ==========================================================
   // timeout signalling

   // status clears by writing 1 to bit 4; a new timeout wins
   assign status_clr = wr_ctrl && i_io_wdata[CTRL_STATUS_BIT];

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst)
         status_reg <= 1'b0;
      else if (expire || force_timeout)
         status_reg <= 1'b1;
      else if (status_clr)
         status_reg <= 1'b0;
   end

   // one pulse per expiry or forced timeout
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst)
         timeout_reg <= 1'b0;
      else
         timeout_reg <= expire || force_timeout;
   end

   // running indication for the board
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst)
         running_reg <= 1'b0;
      else
         running_reg <= wdt_active && (count_next != COUNT_STOPPED);
   end

   // ==========================================================
   // read path

   // locked space and unknown indices read as zero
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         rdata_reg  <= RST_BYTE;
         rvalid_reg <= 1'b0;
      end else begin
         rvalid_reg <= idx_rd || data_rd;
         if (idx_rd)
            rdata_reg <= cfg_open ? index_reg : RST_BYTE;
         else if (data_rd && cfg_open) begin
            if (index_reg == IDX_LDEV_SEL)
               rdata_reg <= ldev_reg;
            else if (wdt_hit(wdt_sel, index_reg, IDX_ACTIVATE))
               rdata_reg <= activate_reg;
            else if (wdt_hit(wdt_sel, index_reg, IDX_UNIT))
               rdata_reg <= unit_reg;
            else if (wdt_hit(wdt_sel, index_reg, IDX_COUNT))
               rdata_reg <= count_reg;
            else if (wdt_hit(wdt_sel, index_reg, IDX_CTRL))
               rdata_reg <= ctrl_image(kbd_en_reg, status_reg);
            else
               rdata_reg <= RST_BYTE;
         end else if (data_rd)
            rdata_reg <= RST_BYTE;
      end
   end

   // ==========================================================
   // outputs

   assign o_io_rdata       = rdata_reg;
   assign o_io_rvalid      = rvalid_reg;
   assign o_wdt_timeout    = timeout_reg;
   assign o_timeout_status = status_reg;
   assign o_wdt_running    = running_reg;
endmodule

// file: dv/wdt_checker_sva.sv
// port-level checks for the indexed port watchdog core
// assumes it is bound onto the core top and shares its one clock
`timescale 1ns/100ps
module wdt_checker (
   // clock and reset
   input wire logic                        i_clk,
   input wire logic                        i_nrst,
   // host I/O port bus
   input wire logic [wdt_pkg::ADDR_W-1:0] i_io_addr,
   input wire logic                        i_io_wr,
   input wire logic                        i_io_rd,
   input wire logic [wdt_pkg::DATA_W-1:0] o_io_rdata,
   input wire logic                        o_io_rvalid,
   // watchdog outputs
   input wire logic                        o_wdt_timeout,
   input wire logic                        o_timeout_status,
   input wire logic                        o_wdt_running
);
   import wdt_pkg::*;
   logic port_hit;

   // ==========================================================
   // helpers
   // a read strobe on either port must be answered in the next cycle
   assign port_hit = (i_io_addr == INDEX_PORT_ADDR) ||
                     (i_io_addr == DATA_PORT_ADDR);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_nrst);

   // ==========================================================
   // assertions
   property p_rd_ans; i_io_rd && port_hit |=> o_io_rvalid; endproperty
   a_rd_ans: assert property (p_rd_ans)
      else $error("port read got no answer");
   property p_rd_cause; o_io_rvalid |-> $past(i_io_rd); endproperty
   a_rd_cause: assert property (p_rd_cause)
      else $error("read answer without a read");
   property p_rdata_hold; !o_io_rvalid |-> $stable(o_io_rdata); endproperty
   a_rdata_hold: assert property (p_rdata_hold)
      else $error("read data moved without an answer");
   property p_pulse; o_wdt_timeout |=> !o_wdt_timeout; endproperty
   a_pulse: assert property (p_pulse)
      else $error("timeout pulse longer than one cycle");
   property p_tout_stat; o_wdt_timeout |-> o_timeout_status; endproperty
   a_tout_stat: assert property (p_tout_stat)
      else $error("timeout without status");
   property p_stat_rise; $rose(o_timeout_status) |-> o_wdt_timeout;
   endproperty
   a_stat_rise: assert property (p_stat_rise)
      else $error("status set without timeout");
   property p_stat_keep; o_timeout_status && !i_io_wr |=> o_timeout_status;
   endproperty
   a_stat_keep: assert property (p_stat_keep)
      else $error("status dropped without a write");
   property p_expire;
      $fell(o_wdt_running) && !$past(i_io_wr) && !$past(i_io_wr, 2)
         |-> ##[0:1] o_wdt_timeout;
   endproperty
   a_expire: assert property (p_expire)
      else $error("count stopped without timeout");
   property p_idle;
      !o_wdt_running && !$past(o_wdt_running) && !$past(i_io_wr)
         |-> !o_wdt_timeout;
   endproperty
   a_idle: assert property (p_idle)
      else $error("timeout while stopped");
endmodule

bind indexed_port_watchdog_timer wdt_checker u_chk (
   .i_clk(i_clk), .i_nrst(i_nrst), .i_io_addr(i_io_addr),
   .i_io_wr(i_io_wr), .i_io_rd(i_io_rd), .o_io_rdata(o_io_rdata),
   .o_io_rvalid(o_io_rvalid), .o_wdt_timeout(o_wdt_timeout),
   .o_timeout_status(o_timeout_status), .o_wdt_running(o_wdt_running));

// file: dv/indexed_port_watchdog_timer_tb.sv
// self-checking bench for the indexed port watchdog core
// assumes a shortened millisecond (10 cycles) so expiries stay short
`timescale 1ns/100ps
module indexed_port_watchdog_timer_tb;
   import wdt_pkg::*;
   localparam int CPM = 10;
   logic        clk;
   logic        nrst = 1'b0;
   logic [15:0] io_addr = 16'h0000;
   logic        io_wr = 1'b0;
   logic        io_rd = 1'b0;
   logic [7:0]  io_wdata = 8'h00;
   logic [7:0]  io_rdata;
   logic        io_rvalid;
   logic        kbd = 1'b0;
   logic        tout;
   logic        tstat;
   logic        running;
   int          failures = 0;
   int          cmp_count = 0;
   int          n;
   logic [7:0]  um [4] = '{8'h00, 8'h18, 8'h08, 8'h10};

   // ==========================================================
   // clock and device
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   indexed_port_watchdog_timer #(.CYCLES_PER_MS(CPM)) dut (
      .i_clk(clk), .i_nrst(nrst), .i_io_addr(io_addr), .i_io_wr(io_wr),
      .i_io_rd(io_rd), .i_io_wdata(io_wdata), .o_io_rdata(io_rdata),
      .o_io_rvalid(io_rvalid), .i_kbd_activity(kbd),
      .o_wdt_timeout(tout), .o_timeout_status(tstat),
      .o_wdt_running(running));

   // ==========================================================
   // access tasks
   task automatic chk(input string nm, input logic [15:0] seen, exp);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // strobes go up and down on falling edges, one idle cycle between
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(negedge clk);
      io_addr = a;
      io_wdata = d;
      io_wr = 1'b1;
      @(negedge clk);
      io_wr = 1'b0;
   endtask
   task automatic rdchk(input string nm, input logic [15:0] a,
                        input logic [7:0] exp);
      @(negedge clk);
      io_addr = a;
      io_rd = 1'b1;
      @(negedge clk);
      io_rd = 1'b0;
      chk("rvalid", {15'h0000, io_rvalid}, 16'h0001);
      @(negedge clk);
      chk("rvalid_end", {15'h0000, io_rvalid}, 16'h0000);
      chk(nm, {8'h00, io_rdata}, {8'h00, exp});
   endtask
   task automatic iw(input logic [7:0] idx, d);
      wr(INDEX_PORT_ADDR, idx);
      wr(DATA_PORT_ADDR, d);
   endtask
   task automatic ird(input string nm, input logic [7:0] idx, exp);
      wr(INDEX_PORT_ADDR, idx);
      rdchk(nm, DATA_PORT_ADDR, exp);
   endtask
   // cycles until the timeout pulse, bounded so a dead timer ends
   task automatic measure;
      n = 0;
      while (tout !== 1'b1 && n < 20000) begin
         @(negedge clk);
         n++;
      end
   endtask
   // a few cycles of slack cover tick and output registering
   task automatic rng(input string nm, input int exp);
      chk(nm, {15'h0000, (n >= exp - 2) && (n <= exp + 4)}, 16'h0001);
   endtask
   // reload 100 cycles, then a clean keyboard pulse after 60
   task automatic kbd_run(input logic [7:0] ctl, input int exp);
      iw(IDX_CTRL, ctl);
      iw(IDX_COUNT, 8'h0a);
      repeat (60) @(negedge clk);
      kbd = 1'b1;
      repeat (6) @(negedge clk);
      kbd = 1'b0;
      measure();
      rng("kbd_expiry", exp);
   endtask
   task automatic summarize;
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // ==========================================================
   // watchdog against a hung run
   initial begin
      #500us;
      failures++;
      summarize();
   end

   // ==========================================================
   // main sequence
   initial begin
      repeat (4) @(negedge clk);
      nrst = 1'b1;
      chk("idle_outs", {13'h0, tstat, running, tout}, 16'h0000);
      // a foreign index write between keys breaks the pair
      wr(INDEX_PORT_ADDR, UNLOCK_KEY);
      wr(INDEX_PORT_ADDR, IDX_ACTIVATE);
      wr(INDEX_PORT_ADDR, UNLOCK_KEY);
      rdchk("locked_idx", INDEX_PORT_ADDR, 8'h00);
      wr(INDEX_PORT_ADDR, UNLOCK_KEY);
      wr(INDEX_PORT_ADDR, IDX_LDEV_SEL);
      rdchk("open_idx", INDEX_PORT_ADDR, IDX_LDEV_SEL);
      iw(IDX_COUNT, 8'h05);
      iw(IDX_LDEV_SEL, LDEV_WATCHDOG);
      ird("ldev", IDX_LDEV_SEL, LDEV_WATCHDOG);
      ird("cnt_ignored", IDX_COUNT, 8'h00);
      ird("act_rst", IDX_ACTIVATE, 8'h00);
      ird("unit_rst", IDX_UNIT, 8'h00);
      ird("ctrl_rst", IDX_CTRL, 8'h00);
      for (int i = 0; i < 4; i++) begin
         iw(IDX_UNIT, um[i]);
         ird("unit_rb", IDX_UNIT, um[i]);
      end
      iw(IDX_ACTIVATE, 8'h01);
      chk("zero_stops", {15'h0, running}, 16'h0000);
      // fast seconds: 3 units of one millisecond, restarted midway
      iw(IDX_COUNT, 8'h03);
      repeat (20) @(negedge clk);
      chk("running", {15'h0, running}, 16'h0001);
      wr(DATA_PORT_ADDR, 8'h03);
      measure();
      rng("restart", 3 * CPM);
      chk("status", {15'h0, tstat}, 16'h0001);
      ird("ctrl_stat", IDX_CTRL, 8'h10);
      chk("stopped", {15'h0, running}, 16'h0000);
      iw(IDX_CTRL, 8'h10);
      ird("stat_clr", IDX_CTRL, 8'h00);
      iw(IDX_UNIT, 8'h18);
      iw(IDX_COUNT, 8'h01);
      measure();
      rng("fast_min", 60 * CPM);
      iw(IDX_UNIT, 8'h00);
      iw(IDX_COUNT, 8'h01);
      measure();
      rng("seconds", 1000 * CPM);
      // clear and force together: the set side wins
      iw(IDX_CTRL, 8'h30);
      measure();
      rng("forced", 0);
      ird("force_self_clr", IDX_CTRL, 8'h10);
      iw(IDX_UNIT, 8'h10);
      kbd_run(8'h50, 98);
      kbd_run(8'h10, 34);
      iw(IDX_ACTIVATE, 8'h00);
      iw(IDX_COUNT, 8'h05);
      chk("disabled", {15'h0, running}, 16'h0000);
      // data writes while locked must not reach the registers
      wr(INDEX_PORT_ADDR, IDX_ACTIVATE);
      wr(INDEX_PORT_ADDR, LOCK_KEY);
      wr(DATA_PORT_ADDR, 8'h01);
      rdchk("locked_rd", DATA_PORT_ADDR, 8'h00);
      wr(INDEX_PORT_ADDR, UNLOCK_KEY);
      wr(INDEX_PORT_ADDR, UNLOCK_KEY);
      rdchk("lock_ignored", DATA_PORT_ADDR, 8'h00);
      summarize();
   end
endmodule
